// file: hw/access_controller_regs.svh
// Register offsets, reset values and bit masks of the access controller
`ifndef ACCESS_CONTROLLER_REGS_SVH
`define ACCESS_CONTROLLER_REGS_SVH

// Word offsets of the two views, byte addresses
`define PROTECT_CLEAR_VIEW_OFS 8'h00
`define PROTECT_SET_VIEW_OFS   8'h04

// Reset values of the protection word per instance
`define BRIDGE0_PROTECT_RESET  32'h00000000
`define BRIDGE1_PROTECT_RESET  32'h00000002
`define BRIDGE2_PROTECT_RESET  32'h00800000

// Implemented protection bits per instance
`define BRIDGE0_PROTECT_MASK   32'h0000007E
`define BRIDGE1_PROTECT_MASK   32'h0000004E
`define BRIDGE2_PROTECT_MASK   32'h000FFFFE

// Peripheral select width on the guarded side
`define PERIPH_SEL_W           5

`endif

// file: hw/access_controller_pkg.sv
// Types shared by the access controller files
package access_controller_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESP = 2'b01
    } resp_state_t;
endpackage

// file: hw/lane_merge.sv
// Byte-lane write mask builder for byte, halfword and word accesses
`timescale 1ns/1ns
`default_nettype none
module lane_merge (
    // Write data and byte strobes
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  byte_en,
    // Ones that are really written
    output logic      [31:0] ones
);
    // Each strobed lane passes its data, others read as zero
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign ones[g*8 +: 8] = byte_en[g] ? wdata[g*8 +: 8] : 8'h00;
        end
    endgenerate
endmodule // lane_merge
`default_nettype wire

// file: hw/access_controller.sv
// Peripheral write-protect controller for one bus bridge
`timescale 1ns/1ns
`default_nettype none
`include "access_controller_regs.svh"
module access_controller
    import access_controller_pkg::*;
#(
    parameter int INSTANCE = 0
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    // Clock gate from the power manager
    input  wire logic                      controller_bus_clock,
    // Register access to the two views
    input  wire logic                      reg_sel,
    input  wire logic                      reg_write,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [3:0]                reg_byte_en,
    input  wire logic [31:0]               reg_wdata,
    output logic      [31:0]               reg_rdata,
    output logic                           reg_ready,
    output logic                           reg_error,
    // Guarded peripheral writes on the same bridge
    input  wire logic                      periph_write,
    input  wire logic [`PERIPH_SEL_W-1:0]  periph_sel,
    input  wire logic                      periph_debug,
    output logic                           periph_allow,
    output logic                           periph_error,
    // Live protection word
    output logic      [31:0]               protect_status
);

    // Reset value and implemented bits picked by instance
    localparam logic [31:0] RST_WORD =
        (INSTANCE == 0) ? `BRIDGE0_PROTECT_RESET :
        (INSTANCE == 1) ? `BRIDGE1_PROTECT_RESET :
                          `BRIDGE2_PROTECT_RESET;
    localparam logic [31:0] IMPL =
        (INSTANCE == 0) ? `BRIDGE0_PROTECT_MASK :
        (INSTANCE == 1) ? `BRIDGE1_PROTECT_MASK :
                          `BRIDGE2_PROTECT_MASK;

    typedef struct packed {
        logic [31:0] prot;
        logic [31:0] rdata;
        logic        ready;
        logic        error;
        logic        allow;
        logic        perr;
        resp_state_t st;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;
    logic [31:0] ones;
    logic        clk_on;
    logic        is_clr;
    logic        is_set;

    // Decoding used for both views
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    lane_merge u_lane (
        .wdata   (reg_wdata),
        .byte_en (reg_byte_en),
        .ones    (ones)
    );

    // Gate only stops the block; state is held, so sleep keeps it valid
    assign clk_on = controller_bus_clock;
    assign is_clr = hit(reg_addr, `PROTECT_CLEAR_VIEW_OFS);
    assign is_set = hit(reg_addr, `PROTECT_SET_VIEW_OFS);

    // Next state
    always_comb begin
        logic [31:0] w;
        w = ones & IMPL;
        nxt_ff = cur_ff;
        nxt_ff.ready = 1'b0;
        nxt_ff.error = 1'b0;
        nxt_ff.allow = 1'b0;
        nxt_ff.perr = 1'b0;
        nxt_ff.st = ST_IDLE;
        if (clk_on) begin
            // Peripheral guard: only this bridge's select bits matter
            if (periph_write) begin
                if (periph_debug || !cur_ff.prot[periph_sel]) begin
                    nxt_ff.allow = 1'b1;
                end else begin
                    nxt_ff.perr = 1'b1;
                end
            end
            if (reg_sel) begin
                nxt_ff.ready = 1'b1;
                nxt_ff.st = ST_RESP;
                nxt_ff.rdata = cur_ff.prot;
                if (reg_write && is_clr) begin
                    nxt_ff.prot = cur_ff.prot & ~w;
                    nxt_ff.error = |(w & ~cur_ff.prot);
                end else if (reg_write && is_set) begin
                    nxt_ff.prot = cur_ff.prot | w;
                    nxt_ff.error = |(w & cur_ff.prot);
                end else if (!is_clr && !is_set) begin
                    nxt_ff.rdata = 32'h00000000;
                    nxt_ff.error = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cur_ff <= '{prot: RST_WORD, rdata: 32'h00000000, ready: 1'b0,
                        error: 1'b0, allow: 1'b0, perr: 1'b0, st: ST_IDLE};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign reg_rdata = cur_ff.rdata;
    assign reg_ready = cur_ff.ready;
    assign reg_error = cur_ff.error;
    assign periph_allow = cur_ff.allow;
    assign periph_error = cur_ff.perr;
    assign protect_status = cur_ff.prot;

    // Response phase decoded from the state field; must track the ready flop
    logic resp_live;
    always_comb begin
        case (cur_ff.st)
            ST_IDLE: begin
                resp_live = 1'b0;
            end
            ST_RESP: begin
                resp_live = 1'b1;
            end
            default: begin
                resp_live = 1'b0;
            end
        endcase
    end

    // Lane strobes spread to a bit mask, built apart from the lane merger
    // so that a fault in the merger cannot hide in its own check
    function automatic logic [31:0] lane_bits(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction
    logic [31:0] strobe_mask;
    assign strobe_mask = lane_bits(reg_byte_en);

    // Checks on the two views
    clear_view_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write && is_clr
        |=> (protect_status & $past(ones) & IMPL) == 32'h00000000)
        else $error("clear view left a bit set");
    set_view_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write && is_set
        |=> (($past(ones) & IMPL) & ~protect_status) == 32'h00000000)
        else $error("set view left a bit clear");
    zero_bits_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write && (is_set || is_clr)
        |=> ((protect_status ^ $past(protect_status)) & ~$past(ones))
            == 32'h00000000)
        else $error("zero bit changed state");
    same_read_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && (is_set || is_clr)
        |=> reg_rdata == $past(protect_status))
        else $error("view read mismatch");
    read_keeps_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && !reg_write |=> $stable(protect_status))
        else $error("read changed protection");
    unmapped_err_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && !is_clr && !is_set
        |=> reg_error && reg_rdata == 32'h00000000
            && $stable(protect_status))
        else $error("unmapped access not refused");

    // Checks on the request and answer handshake
    answer_pulse_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel |=> reg_ready)
        else $error("request not answered");
    idle_quiet_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        !reg_sel |=> !reg_ready && !reg_error)
        else $error("answer without request");
    lane_guard_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write
        |=> ((protect_status ^ $past(protect_status))
            & ~$past(strobe_mask)) == 32'h00000000)
        else $error("unstrobed lane changed");
    resp_track_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        reg_ready == resp_live)
        else $error("response state out of step");
    error_ready_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        reg_error |-> reg_ready)
        else $error("error without answer");

    // Checks on the peripheral guard
    block_write_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && periph_write && !periph_debug && protect_status[periph_sel]
        |=> periph_error && !periph_allow)
        else $error("protected write not blocked");
    guard_excl_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        !(periph_allow && periph_error))
        else $error("allow and error together");
    open_pass_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && periph_write && !protect_status[periph_sel]
        |=> periph_allow && !periph_error)
        else $error("open peripheral blocked");
    guard_idle_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        !(clk_on && periph_write) |=> !periph_allow && !periph_error)
        else $error("guard answered without write");
    debug_pass_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && periph_write && periph_debug |=> periph_allow && !periph_error)
        else $error("debugger write blocked");

    // Checks on double operations and unassigned bits
    double_set_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write && is_set
        && |(ones & IMPL & protect_status) |=> reg_error)
        else $error("double protect not flagged");
    double_clr_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write && is_clr
        && |(ones & IMPL & ~protect_status) |=> reg_error)
        else $error("double unprotect not flagged");
    unimpl_bits_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        (protect_status & ~IMPL) == (RST_WORD & ~IMPL))
        else $error("unassigned bit moved");
    quiet_unimpl_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        clk_on && reg_sel && reg_write && (is_set || is_clr)
        && (ones & IMPL) == 32'h00000000 |=> !reg_error)
        else $error("unassigned bit raised error");

    // Checks on gating and reset
    gated_hold_a:
        assert property (@(posedge sys_clk) disable iff (srst)
        !clk_on |=> $stable(protect_status) && !reg_ready)
        else $error("state moved while gated");
    reset_word_a:
        assert property (@(posedge sys_clk)
        srst |=> protect_status == RST_WORD)
        else $error("wrong reset word");
    reset_quiet_a:
        assert property (@(posedge sys_clk)
        srst |=> !reg_ready && !reg_error && !periph_allow && !periph_error)
        else $error("answer pending after reset");

    // Main scenarios worth seeing at least once
    cov_set_c: cover property (@(posedge sys_clk)
        reg_sel && reg_write && is_set && |(ones & IMPL));
    cov_clr_c: cover property (@(posedge sys_clk)
        reg_sel && reg_write && is_clr && |(ones & IMPL));
    cov_block_c: cover property (@(posedge sys_clk) periph_error);
    cov_debug_c: cover property (@(posedge sys_clk)
        periph_write && periph_debug && protect_status[periph_sel]);
    cov_double_c: cover property (@(posedge sys_clk)
        reg_ready && reg_error);

endmodule // access_controller
`default_nettype wire

// file: verif/host_model.sv
// Processor-side register master model for the access controller
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock
    input  wire logic        sys_clk,
    // Register request
    output logic             reg_sel,
    output logic             reg_write,
    output logic [7:0]       reg_addr,
    output logic [3:0]       reg_byte_en,
    output logic [31:0]      reg_wdata
);
    // Idle bus at time zero
    initial begin
        reg_sel = 1'b0;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_byte_en = 4'h0;
        reg_wdata = 32'h0;
    end
    // One-cycle request; released data flips so stale values never match
    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        @(negedge sys_clk);
        reg_sel = 1'b1;
        reg_write = wr;
        reg_addr = a;
        reg_byte_en = be;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_sel = 1'b0;
        reg_wdata = ~d;
    endtask
endmodule // host_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the access controller, bridge one map
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct {
        logic wr; logic [7:0] a; logic [3:0] be;
        logic [31:0] d; logic [31:0] st; logic er;
    } row_t;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        controller_bus_clock = 1'b1;
    logic        periph_write = 1'b0;
    logic        periph_debug = 1'b0;
    logic [4:0]  periph_sel = 5'h00;
    logic        reg_sel, reg_write, reg_ready, reg_error;
    logic        periph_allow, periph_error;
    logic [7:0]  reg_addr;
    logic [3:0]  reg_byte_en;
    logic [31:0] reg_wdata, reg_rdata, protect_status;
    int          fails = 0;
    int          check_count = 0;
    // Write or read, address, lanes, data, status and error expected
    row_t rows[9] = '{
        '{1'b0, 8'h00, 4'hF, 32'h0, 32'h2, 1'b0},
        '{1'b0, 8'h04, 4'hF, 32'h0, 32'h2, 1'b0},
        '{1'b1, 8'h04, 4'h1, 32'h48, 32'h4A, 1'b0},
        '{1'b1, 8'h00, 4'h1, 32'h08, 32'h42, 1'b0},
        '{1'b1, 8'h00, 4'h1, 32'h08, 32'h42, 1'b1},
        '{1'b1, 8'h04, 4'h1, 32'h40, 32'h42, 1'b1},
        '{1'b1, 8'h04, 4'hE, 32'hFFFFFF04, 32'h42, 1'b0},
        '{1'b1, 8'h00, 4'hF, 32'h42, 32'h0, 1'b0},
        '{1'b1, 8'h08, 4'hF, 32'h4E, 32'h0, 1'b1}};
    // Half period of 25 ns gives 20 MHz
    always #25 sys_clk = ~sys_clk;
    access_controller #(.INSTANCE(1)) access_controller_i (
        .sys_clk, .srst, .controller_bus_clock, .reg_sel, .reg_write,
        .reg_addr, .reg_byte_en, .reg_wdata, .reg_rdata, .reg_ready,
        .reg_error, .periph_write, .periph_sel, .periph_debug,
        .periph_allow, .periph_error, .protect_status);
    host_model host_model_i (.sys_clk, .reg_sel, .reg_write, .reg_addr,
        .reg_byte_en, .reg_wdata);
    task automatic chk(input string n, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Peripheral write; result packed as allow then error
    task automatic periph(input logic [4:0] s, input logic dbg,
                          input logic [1:0] exp);
        @(negedge sys_clk);
        periph_write = 1'b1;
        periph_sel = s;
        periph_debug = dbg;
        @(negedge sys_clk);
        periph_write = 1'b0;
        chk("periph", {30'h0, periph_allow, periph_error}, {30'h0, exp});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, well beyond the roughly 46 cycles needed
    initial begin
        repeat (2000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end
    // Main sequence: table first, then peripheral, gating and reset
    initial begin
        repeat (12) @(negedge sys_clk);
        srst = 1'b0;
        chk("status", protect_status, 32'h2);
        chk("ready", {31'h0, reg_ready}, 32'h0);
        foreach (rows[i]) begin
            host_model_i.acc(rows[i].wr, rows[i].a, rows[i].be, rows[i].d);
            chk("ready", {31'h0, reg_ready}, 32'h1);
            chk("status", protect_status, rows[i].st);
            chk("error", {31'h0, reg_error}, {31'h0, rows[i].er});
            if (!rows[i].wr)
                chk("rdata", reg_rdata, rows[i].st);
        end
        host_model_i.acc(1'b1, 8'h04, 4'h1, 32'h08);
        periph(5'd3, 1'b0, 2'b01);
        periph(5'd3, 1'b1, 2'b10);
        periph(5'd2, 1'b0, 2'b10);
        host_model_i.acc(1'b0, 8'h04, 4'hF, 32'h0);
        chk("rdata", reg_rdata, 32'h8);
        // Gated bus clock: request must be ignored, no answer
        controller_bus_clock = 1'b0;
        host_model_i.acc(1'b1, 8'h00, 4'hF, 32'h08);
        chk("ready", {31'h0, reg_ready}, 32'h0);
        chk("status", protect_status, 32'h8);
        controller_bus_clock = 1'b1;
        host_model_i.acc(1'b1, 8'h00, 4'hF, 32'h08);
        chk("status", protect_status, 32'h0);
        @(negedge sys_clk);
        srst = 1'b1;
        @(negedge sys_clk);
        srst = 1'b0;
        chk("status", protect_status, 32'h2);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
